// File: rtl/cxmw_pkg.sv
// Shared constants, bus carriers and state types of the transceiver mode and wake controller
package cxmw_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_ADDR   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;

  // Control register fields
  localparam int unsigned CTRL_LWU_STBY_BIT   = 0;
  localparam int unsigned CTRL_LWU_STBY_RESET = 0;

  // Status register fields
  localparam int unsigned ST_MODE_LSB      = 0;
  localparam int unsigned ST_MODE_W        = 3;
  localparam int unsigned ST_WAKE_REQUEST_FLAG_BIT    = 3;
  localparam int unsigned ST_POWER_ON_FLAG_BIT     = 4;
  localparam int unsigned ST_SRC_REM_BIT   = 5;
  localparam int unsigned ST_SRC_LOC_BIT   = 6;
  localparam int unsigned ST_LFAIL_BIT     = 7;
  localparam int unsigned ST_PHASE_LSB     = 8;
  localparam int unsigned ST_PHASE_W       = 2;

  // Clock and timing figures
  localparam int unsigned CLK_MHZ          = 25;
  localparam int unsigned SLEEP_DELAY_US   = 50;
  localparam int unsigned WAKE_FILTER_NS   = 1000;
  localparam int unsigned WAKE_TIMEOUT_US  = 1000;
  localparam int unsigned SLEEP_DELAY_CYC  = SLEEP_DELAY_US * CLK_MHZ;
  localparam int unsigned WAKE_FILTER_CYC  = (WAKE_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_TIMEOUT_CYC = WAKE_TIMEOUT_US * CLK_MHZ;
  // One bit at 500 kbit/s lasts 2000 ns
  localparam int unsigned SLOW_BIT_NS      = 2000;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_STANDBY,
    MODE_NORMAL,
    MODE_SILENT,
    MODE_GOTOSLEEP,
    MODE_SLEEP
  } cxmw_mode_type;

  // Remote wake pattern detector phases
  typedef enum logic [1:0] {
    WUP_IDLE,
    WUP_WAIT_REC,
    WUP_WAIT_DOM
  } cxmw_wup_type;

  // Classic Wishbone request and answer
  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADDR_W-1:0] adr;
    logic [3:0]        sel;
    logic [DATA_W-1:0] dat;
  } cxmw_wb_req_type;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] dat;
  } cxmw_wb_rsp_type;

endpackage

// File: rtl/cxmw_top.sv
// Mode control and wake detection of a CAN FD transceiver, with a Wishbone status port
//
// Notes on behaviour
// - EN high, standby request low: go-to-sleep
// - After sleep delay: sleep, supply enable off
// - Normal: drive bus from transmit, mirror bus
// - Entering normal clears wake and power-on flags
// - Silent: driver off, receiver still mirrors bus
// - Silent: fault pin shows power-on, local failure
// - Standby: driver, receiver off; supply enable on
// - Standby: receive output low on pending wake
// - Back in normal, fault pin shows a local wake source
// - Pending wake keeps standby instead of sleep
// - Sleep: bus and wake pin monitors stay on
// - Sleep exits: remote wake, local wake, request
// - Remote wake detector runs in standby, sleep
// - Dominant, recessive, dominant; traffic never resets
// - Second dominant done: recognise, receive output low
// - Hold wake until I/O supply valid
// - State filtered only after exceeding filter time
// - Filter shorter than one 500k bit
// - Pattern must finish within timeout, else reset
// - Either wake pin edge raises local wake
// - Local wake on in sleep, off in normal
// - Request and mode-select pins choose the mode
`timescale 1ns/100ps
module cxmw_top #(
  parameter int unsigned SLEEP_CYC   = cxmw_pkg::SLEEP_DELAY_CYC,
  parameter int unsigned FILTER_CYC  = cxmw_pkg::WAKE_FILTER_CYC,
  parameter int unsigned TIMEOUT_CYC = cxmw_pkg::WAKE_TIMEOUT_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire cxmw_pkg::cxmw_wb_req_type wb_req_i,
  output cxmw_pkg::cxmw_wb_rsp_type      wb_rsp_o,
  input  wire logic                      txd_i,
  input  wire logic                      mode_select_i,
  input  wire logic                      low_power_request_n_i,
  input  wire logic                      bus_dominant_i,
  input  wire logic                      wake_pin_i,
  input  wire logic                      core_supply_ok_i,
  input  wire logic                      io_supply_ok_i,
  input  wire logic                      battery_supply_ok_i,
  input  wire logic                      local_failure_i,
  output logic                           bus_drive_dominant_o,
  output logic                           bus_driver_en_o,
  output logic                           receiver_en_o,
  output logic                           low_power_monitor_en_o,
  output logic                           rxd_o,
  output logic                           rxd_oe_o,
  output logic                           supply_enable_out_o,
  output logic                           supply_enable_oe_o,
  output logic                           fault_indicator_n_o
);

  // Sleep and timeout counters need room for their own figure, the filter run for one more
  localparam int unsigned SLP_W = $clog2(SLEEP_CYC + 1);
  localparam int unsigned FLT_W = $clog2(FILTER_CYC + 2);
  localparam int unsigned TMO_W = $clog2(TIMEOUT_CYC + 1);

  // Refuse timings the counters cannot serve
  if (SLEEP_CYC < 1 || FILTER_CYC < 1 || TIMEOUT_CYC <= 3 * FILTER_CYC) begin : g_bad_timing
    $error("cxmw_top: timing parameters out of range");
  end
  if (FILTER_CYC * 1000 >= cxmw_pkg::SLOW_BIT_NS * cxmw_pkg::CLK_MHZ) begin : g_bad_filter
    $error("cxmw_top: wake filter longer than one slow bit");
  end

  // Battery loss clears the protected state without a clock edge
  logic batt_lost;
  assign batt_lost = ~battery_supply_ok_i;

  // Two-stage synchronisers for every pin-level input except transmit and battery supply
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  always_ff @(posedge clk_i) begin
    sync1_q <= {local_failure_i, io_supply_ok_i, core_supply_ok_i, wake_pin_i,
                bus_dominant_i, low_power_request_n_i, mode_select_i};
    sync2_q <= sync1_q;
  end

  logic en_s, stb_n_s, dom_s, wake_s, core_ok, io_ok, lfail_s;
  assign {lfail_s, io_ok, core_ok, wake_s, dom_s, stb_n_s, en_s} = sync2_q;

  logic supplies_ok;
  assign supplies_ok = core_ok & io_ok;

  cxmw_pkg::cxmw_mode_type mode_q;
  cxmw_pkg::cxmw_mode_type mode_d;
  logic                    wake_request_flag_q;
  logic                    power_on_flag_q;
  logic                    src_rem_q;
  logic                    src_loc_q;
  logic                    lwu_stby_en_q;
  logic                    wup_hit;
  logic                    lwu_hit;

  // Monitors sit idle while the link is active
  function automatic logic low_power_mode(input cxmw_pkg::cxmw_mode_type m);
    return (m == cxmw_pkg::MODE_STANDBY) || (m == cxmw_pkg::MODE_GOTOSLEEP) || (m == cxmw_pkg::MODE_SLEEP);
  endfunction

  // ---------------- Bus state filter ----------------
  // Run length of the current bus level, saturating one past the filter
  logic             last_dom_q;
  logic [FLT_W-1:0] run_q;
  logic             flt_event;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_dom_q <= 1'b0;
      run_q      <= '0;
    end else begin
      last_dom_q <= dom_s;
      if (dom_s != last_dom_q) begin
        run_q <= '0;
      end else if (run_q <= FLT_W'(FILTER_CYC)) begin
        run_q <= run_q + 1'b1;
      end
    end
  end
  // Counts once, only when the level has outlasted the filter time
  assign flt_event = (dom_s == last_dom_q) && (run_q == FLT_W'(FILTER_CYC));

  // ---------------- Remote wake pattern detector ----------------
  cxmw_pkg::cxmw_wup_type wup_q;
  logic [TMO_W-1:0]       tmo_q;
  logic                   tmo_done;
  assign tmo_done = (tmo_q == TMO_W'(TIMEOUT_CYC));

  always_ff @(posedge clk_i or posedge batt_lost) begin
    if (batt_lost) begin
      wup_q <= cxmw_pkg::WUP_IDLE;
      tmo_q <= '0;
    end else if (rst_i || !low_power_mode(mode_q)) begin
      wup_q <= cxmw_pkg::WUP_IDLE;
      tmo_q <= '0;
    end else begin
      case (wup_q)
        cxmw_pkg::WUP_IDLE: begin
          tmo_q <= '0;
          if (flt_event && dom_s) begin
            wup_q <= cxmw_pkg::WUP_WAIT_REC;
          end
        end
        cxmw_pkg::WUP_WAIT_REC: begin
          tmo_q <= tmo_q + 1'b1;
          if (tmo_done) begin
            wup_q <= cxmw_pkg::WUP_IDLE;
          end else if (flt_event && !dom_s) begin
            wup_q <= cxmw_pkg::WUP_WAIT_DOM;
          end
        end
        cxmw_pkg::WUP_WAIT_DOM: begin
          tmo_q <= tmo_q + 1'b1;
          if (tmo_done) begin
            wup_q <= cxmw_pkg::WUP_IDLE;
          end else if (flt_event && dom_s) begin
            wup_q <= cxmw_pkg::WUP_IDLE;
          end
        end
        default: begin
          wup_q <= cxmw_pkg::WUP_IDLE;
          tmo_q <= '0;
        end
      endcase
    end
  end
  // A dominant still standing at timeout has its run saturated, so the far node must release first
  assign wup_hit = (wup_q == cxmw_pkg::WUP_WAIT_DOM) && !tmo_done && flt_event && dom_s;

  // ---------------- Local wake pin monitor ----------------
  logic wake_prev_q;
  logic lwu_active;
  assign lwu_active = (mode_q == cxmw_pkg::MODE_SLEEP) ||
                      (lwu_stby_en_q && (mode_q == cxmw_pkg::MODE_STANDBY || mode_q == cxmw_pkg::MODE_GOTOSLEEP));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_prev_q <= 1'b0;
    end else begin
      wake_prev_q <= wake_s;
    end
  end
  // Prev level tracks even while off, so switching on never fakes an edge
  assign lwu_hit = lwu_active && (wake_s != wake_prev_q);

  // ---------------- Mode machine ----------------
  logic [SLP_W-1:0] slp_q;
  logic             slp_done;
  assign slp_done = (slp_q == SLP_W'(SLEEP_CYC));

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      cxmw_pkg::MODE_SLEEP: begin
        if (stb_n_s && supplies_ok) begin
          mode_d = en_s ? cxmw_pkg::MODE_NORMAL : cxmw_pkg::MODE_SILENT;
        end else if (wup_hit || lwu_hit) begin
          mode_d = cxmw_pkg::MODE_STANDBY;
        end
      end
      cxmw_pkg::MODE_STANDBY, cxmw_pkg::MODE_NORMAL, cxmw_pkg::MODE_SILENT, cxmw_pkg::MODE_GOTOSLEEP: begin
        if (stb_n_s) begin
          if (!supplies_ok) begin
            mode_d = cxmw_pkg::MODE_STANDBY;
          end else begin
            mode_d = en_s ? cxmw_pkg::MODE_NORMAL : cxmw_pkg::MODE_SILENT;
          end
        end else if (!en_s) begin
          mode_d = cxmw_pkg::MODE_STANDBY;
        end else if (wake_request_flag_q || wup_hit || lwu_hit) begin
          mode_d = cxmw_pkg::MODE_STANDBY;
        end else if (mode_q == cxmw_pkg::MODE_GOTOSLEEP && slp_done) begin
          mode_d = cxmw_pkg::MODE_SLEEP;
        end else begin
          mode_d = cxmw_pkg::MODE_GOTOSLEEP;
        end
      end
      default: mode_d = cxmw_pkg::MODE_STANDBY;
    endcase
  end

  always_ff @(posedge clk_i or posedge batt_lost) begin
    if (batt_lost) begin
      mode_q <= cxmw_pkg::MODE_STANDBY;
    end else if (rst_i) begin
      mode_q <= cxmw_pkg::MODE_STANDBY;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Sleep entry delay counts only while go-to-sleep is held
  always_ff @(posedge clk_i or posedge batt_lost) begin
    if (batt_lost) begin
      slp_q <= '0;
    end else if (rst_i || mode_q != cxmw_pkg::MODE_GOTOSLEEP) begin
      slp_q <= '0;
    end else if (!slp_done) begin
      slp_q <= slp_q + 1'b1;
    end
  end

  // ---------------- Flags ----------------
  logic enter_normal;
  assign enter_normal = (mode_d == cxmw_pkg::MODE_NORMAL) && (mode_q != cxmw_pkg::MODE_NORMAL);

  // Wake arriving in the very cycle of the clear is kept
  always_ff @(posedge clk_i or posedge batt_lost) begin
    if (batt_lost) begin
      wake_request_flag_q <= 1'b0;
      power_on_flag_q  <= 1'b1;
    end else if (rst_i) begin
      wake_request_flag_q <= 1'b0;
      power_on_flag_q  <= 1'b1;
    end else begin
      if (wup_hit || lwu_hit) begin
        wake_request_flag_q <= 1'b1;
      end else if (enter_normal) begin
        wake_request_flag_q <= 1'b0;
      end
      if (enter_normal) begin
        power_on_flag_q <= 1'b0;
      end
    end
  end

  // Last wake source, kept for reporting after return to normal
  always_ff @(posedge clk_i or posedge batt_lost) begin
    if (batt_lost) begin
      src_rem_q <= 1'b0;
      src_loc_q <= 1'b0;
    end else if (rst_i) begin
      src_rem_q <= 1'b0;
      src_loc_q <= 1'b0;
    end else if (wup_hit || lwu_hit) begin
      src_rem_q <= wup_hit;
      src_loc_q <= lwu_hit;
    end
  end

  // ---------------- Pin outputs ----------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_drive_dominant_o   <= 1'b0;
      bus_driver_en_o        <= 1'b0;
      receiver_en_o          <= 1'b0;
      low_power_monitor_en_o <= 1'b1;
      rxd_o                  <= 1'b1;
      rxd_oe_o               <= 1'b0;
      supply_enable_out_o    <= 1'b1;
      supply_enable_oe_o     <= 1'b1;
      fault_indicator_n_o    <= 1'b1;
    end else begin
      bus_driver_en_o        <= (mode_q == cxmw_pkg::MODE_NORMAL);
      bus_drive_dominant_o   <= (mode_q == cxmw_pkg::MODE_NORMAL) && !txd_i;
      receiver_en_o          <= (mode_q == cxmw_pkg::MODE_NORMAL) || (mode_q == cxmw_pkg::MODE_SILENT);
      low_power_monitor_en_o <= low_power_mode(mode_q);
      supply_enable_out_o    <= 1'b1;
      supply_enable_oe_o     <= (mode_q != cxmw_pkg::MODE_SLEEP);
      // Receive output only drives with a valid I/O supply
      rxd_oe_o <= io_ok;
      case (mode_q)
        cxmw_pkg::MODE_NORMAL, cxmw_pkg::MODE_SILENT: rxd_o <= !dom_s;
        cxmw_pkg::MODE_STANDBY:                     rxd_o <= !wake_request_flag_q;
        default:                                    rxd_o <= 1'b1;
      endcase
      case (mode_q)
        cxmw_pkg::MODE_SILENT: fault_indicator_n_o <= !(power_on_flag_q || lfail_s);
        cxmw_pkg::MODE_NORMAL: fault_indicator_n_o <= !src_loc_q;
        default:               fault_indicator_n_o <= 1'b1;
      endcase
    end
  end

  // ---------------- Wishbone slave ----------------
  logic              ack_q;
  logic [31:0]       rdat_q;
  logic              wb_hit;
  assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !ack_q;

  function automatic logic [31:0] status_word();
    logic [31:0] w;
    w = '0;
    w[cxmw_pkg::ST_MODE_LSB +: cxmw_pkg::ST_MODE_W]   = mode_q;
    w[cxmw_pkg::ST_WAKE_REQUEST_FLAG_BIT]                        = wake_request_flag_q;
    w[cxmw_pkg::ST_POWER_ON_FLAG_BIT]                         = power_on_flag_q;
    w[cxmw_pkg::ST_SRC_REM_BIT]                       = src_rem_q;
    w[cxmw_pkg::ST_SRC_LOC_BIT]                       = src_loc_q;
    w[cxmw_pkg::ST_LFAIL_BIT]                         = lfail_s;
    w[cxmw_pkg::ST_PHASE_LSB +: cxmw_pkg::ST_PHASE_W] = wup_q;
    return w;
  endfunction

  // One wait state; unmapped reads answer zero, unmapped writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q         <= 1'b0;
      rdat_q        <= '0;
      lwu_stby_en_q <= 1'(cxmw_pkg::CTRL_LWU_STBY_RESET);
    end else begin
      ack_q  <= wb_hit;
      rdat_q <= '0;
      if (wb_hit && !wb_req_i.we) begin
        if (wb_req_i.adr == cxmw_pkg::CTRL_ADDR) begin
          rdat_q[cxmw_pkg::CTRL_LWU_STBY_BIT] <= lwu_stby_en_q;
        end else if (wb_req_i.adr == cxmw_pkg::STATUS_ADDR) begin
          rdat_q <= status_word();
        end
      end
      if (wb_hit && wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr == cxmw_pkg::CTRL_ADDR) begin
        lwu_stby_en_q <= wb_req_i.dat[cxmw_pkg::CTRL_LWU_STBY_BIT];
      end
    end
  end
  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = rdat_q;

  // ---------------- Checks ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || batt_lost);

  a_gotosleep_entry: assert property (
    (mode_q == cxmw_pkg::MODE_NORMAL && !stb_n_s && en_s && !wake_request_flag_q && !wup_hit && !lwu_hit)
      |=> mode_q == cxmw_pkg::MODE_GOTOSLEEP)
    else $error("go-to-sleep not entered");

  a_sleep_after_delay: assert property (
    (mode_q == cxmw_pkg::MODE_GOTOSLEEP && slp_done && !stb_n_s && en_s && !wake_request_flag_q && !wup_hit && !lwu_hit)
      |=> mode_q == cxmw_pkg::MODE_SLEEP ##1 !supply_enable_oe_o)
    else $error("sleep or supply release missing");

  a_sleep_not_early: assert property (
    (mode_q != cxmw_pkg::MODE_SLEEP) ##1 (mode_q == cxmw_pkg::MODE_SLEEP)
      |-> $past(mode_q) == cxmw_pkg::MODE_GOTOSLEEP && $past(slp_q) == SLP_W'(SLEEP_CYC))
    else $error("sleep entered before delay");

  a_normal_clears: assert property (
    enter_normal && !wup_hit && !lwu_hit |=> !wake_request_flag_q && !power_on_flag_q)
    else $error("flags not cleared in normal");

  a_silent_no_drive: assert property (
    mode_q == cxmw_pkg::MODE_SILENT ##1 mode_q == cxmw_pkg::MODE_SILENT |-> !bus_driver_en_o && !bus_drive_dominant_o)
    else $error("driver active in silent");

  a_standby_rxd_wake: assert property (
    mode_q == cxmw_pkg::MODE_STANDBY && wake_request_flag_q |=> !rxd_o)
    else $error("pending wake not shown on receive output");

  a_pending_stays: assert property (
    wake_request_flag_q && !stb_n_s && mode_q == cxmw_pkg::MODE_STANDBY |=> mode_q == cxmw_pkg::MODE_STANDBY)
    else $error("left standby with wake pending");

  a_wup_sets_flag: assert property (
    wup_hit |=> wake_request_flag_q ##1 (!rxd_o || mode_q != cxmw_pkg::MODE_STANDBY || $past(mode_q) != cxmw_pkg::MODE_STANDBY))
    else $error("recognised pattern lost");

  a_wup_timeout: assert property (
    wup_q != cxmw_pkg::WUP_IDLE && tmo_done && low_power_mode(mode_q) |=> wup_q == cxmw_pkg::WUP_IDLE)
    else $error("pattern survived timeout");

  a_filter_min: assert property (
    $changed(dom_s) |-> !flt_event [*2])
    else $error("short bus state counted");

  a_lwu_off_normal: assert property (
    mode_q == cxmw_pkg::MODE_NORMAL |-> !lwu_hit)
    else $error("local wake active in normal");

  a_wb_ack_once: assert property (
    ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");

endmodule

// File: verif/cxmw_bus_model.sv
// Behavioural bus and remote node model that sends wake patterns
`timescale 1ns/100ps
module cxmw_bus_model (
  input  wire logic       clk_i,
  input  wire logic       send_i,
  input  wire logic [8:0] dom_len_i,
  input  wire logic [8:0] gap_len_i,
  input  wire logic       drive_i,
  output logic            busy_o,
  output logic            bus_dominant_o
);
  logic pat_q;

  initial begin
    pat_q = 1'b0;
    busy_o = 1'b0;
  end

  // Wired bus: any dominant source wins, termination gives recessive
  assign bus_dominant_o = pat_q | drive_i;

  // Dominant, recessive, dominant, then a recessive tail before the next pattern
  always @(posedge clk_i) begin
    if (send_i && !busy_o) begin
      busy_o <= 1'b1;
      pat_q <= 1'b1;
      repeat (dom_len_i) @(posedge clk_i);
      pat_q <= 1'b0;
      repeat (gap_len_i) @(posedge clk_i);
      pat_q <= 1'b1;
      repeat (dom_len_i) @(posedge clk_i);
      pat_q <= 1'b0;
      repeat (8) @(posedge clk_i);
      busy_o <= 1'b0;
    end
  end
endmodule

// File: verif/tb_can_transceiver_mode_wake_control.sv
// Self-checking bench of the mode and wake controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_can_transceiver_mode_wake_control;
  localparam int unsigned SL = 20;
  localparam int unsigned FI = 4;
  localparam int unsigned TO = 200;
  logic                      clk_i, rst_i, txd, en, lp_n, wake, fail, send, io;
  logic                      drv, drv_en, rx_en, mon_en, rxd, rxd_oe, sup, sup_oe, fault_n, busy, bus;
  logic [8:0]                dl, gl;
  logic [31:0]               s;
  int                        mismatches, num_checks;
  cxmw_pkg::cxmw_wb_req_type req;
  cxmw_pkg::cxmw_wb_rsp_type rsp;

  cxmw_top #(.SLEEP_CYC(SL), .FILTER_CYC(FI), .TIMEOUT_CYC(TO)) cxmw_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .txd_i(txd),
    .mode_select_i(en), .low_power_request_n_i(lp_n), .bus_dominant_i(bus), .wake_pin_i(wake),
    .core_supply_ok_i(1'b1), .io_supply_ok_i(io), .battery_supply_ok_i(1'b1), .local_failure_i(fail),
    .bus_drive_dominant_o(drv), .bus_driver_en_o(drv_en), .receiver_en_o(rx_en),
    .low_power_monitor_en_o(mon_en), .rxd_o(rxd), .rxd_oe_o(rxd_oe), .supply_enable_out_o(sup),
    .supply_enable_oe_o(sup_oe), .fault_indicator_n_o(fault_n));
  // Device drives the bus only while its driver is enabled
  cxmw_bus_model cxmw_bus_model_inst (.clk_i(clk_i), .send_i(send), .dom_len_i(dl), .gap_len_i(gl),
    .drive_i(drv & drv_en), .busy_o(busy), .bus_dominant_o(bus));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Settle past the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic pins(input logic e, input logic n);
    @(posedge clk_i);
    en <= e;
    lp_n <= n;
    cyc(8);
  endtask

  // Classic single Wishbone cycle; waits for ack, bounded
  task automatic wb(input logic we, input logic [7:0] a, output logic [31:0] q);
    int k;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: 32'h0000_0001};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (rsp.ack !== 1'b1 && k < 20);
    q = rsp.dat;
    if (k >= 20) mismatches++;
    req <= '0;
    @(posedge clk_i);
  endtask

  task automatic rd_st();
    wb(1'b0, cxmw_pkg::STATUS_ADDR, s);
  endtask

  // One wake pattern from the remote node, then wait for its tail
  task automatic pattern(input logic [8:0] d, input logic [8:0] g);
    int k;
    @(posedge clk_i);
    dl <= d;
    gl <= g;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    // Busy rises at the edge that takes send, so look one edge later
    @(posedge clk_i);
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge clk_i);
      k++;
    end
    cyc(6);
  endtask

  task automatic t_reset();
    rd_st();
    `CHK("mode", cxmw_pkg::MODE_STANDBY, s[2:0])
    `CHK("power_on_flag", 1'b1, s[cxmw_pkg::ST_POWER_ON_FLAG_BIT])
    wb(1'b0, 8'h10, s);
    `CHK("unmapped", 32'h0000_0000, s)
    `CHK("sup_oe", 1'b1, sup_oe)
    `CHK("monitor", 1'b1, mon_en)
    `CHK("rxd_oe", 1'b1, rxd_oe)
    wb(1'b1, cxmw_pkg::CTRL_ADDR, s);
    wb(1'b0, cxmw_pkg::CTRL_ADDR, s);
    `CHK("ctrl", 32'h0000_0001, s)
    $display("test reset done");
  endtask

  task automatic t_normal();
    pins(1'b1, 1'b1);
    rd_st();
    `CHK("mode", cxmw_pkg::MODE_NORMAL, s[2:0])
    `CHK("power_on_flag", 1'b0, s[cxmw_pkg::ST_POWER_ON_FLAG_BIT])
    @(posedge clk_i);
    txd <= 1'b0;
    cyc(6);
    `CHK("drive", 1'b1, drv & drv_en)
    `CHK("rxd", 1'b0, rxd)
    @(posedge clk_i);
    txd <= 1'b1;
    cyc(6);
    `CHK("rxd", 1'b1, rxd)
    $display("test normal done");
  endtask

  task automatic t_silent();
    pins(1'b0, 1'b1);
    @(posedge clk_i);
    txd <= 1'b0;
    fail <= 1'b1;
    cyc(6);
    `CHK("drv_en", 1'b0, drv_en)
    `CHK("rx_en", 1'b1, rx_en)
    `CHK("fault", 1'b0, fault_n)
    @(posedge clk_i);
    txd <= 1'b1;
    fail <= 1'b0;
    cyc(6);
    `CHK("fault", 1'b1, fault_n)
    $display("test silent done");
  endtask

  task automatic t_sleep();
    pins(1'b1, 1'b0);
    rd_st();
    `CHK("mode", cxmw_pkg::MODE_GOTOSLEEP, s[2:0])
    `CHK("sup_oe", 1'b1, sup_oe)
    cyc(SL + 4);
    `CHK("sup_oe", 1'b0, sup_oe)
    `CHK("sup", 1'b1, sup)
    `CHK("rx_en", 1'b0, rx_en | drv_en)
    `CHK("monitor", 1'b1, mon_en)
    $display("test sleep done");
  endtask

  task automatic t_remote();
    pattern(9'd2, 9'd2);
    rd_st();
    `CHK("mode", cxmw_pkg::MODE_SLEEP, s[2:0])
    pattern(9'd8, 9'd300);
    cyc(TO + 40);
    rd_st();
    `CHK("mode", cxmw_pkg::MODE_SLEEP, s[2:0])
    // Pattern completes without a valid I/O supply; wake must be held
    @(posedge clk_i);
    io <= 1'b0;
    pattern(9'd8, 9'd8);
    `CHK("rxd_oe", 1'b0, rxd_oe)
    @(posedge clk_i);
    io <= 1'b1;
    cyc(6);
    `CHK("rxd_oe", 1'b1, rxd_oe)
    `CHK("rxd", 1'b0, rxd)
    rd_st();
    `CHK("mode", cxmw_pkg::MODE_STANDBY, s[2:0])
    `CHK("src", 1'b1, s[cxmw_pkg::ST_SRC_REM_BIT])
    pins(1'b1, 1'b1);
    `CHK("fault", 1'b1, fault_n)
    $display("test remote done");
  endtask

  task automatic t_local();
    pins(1'b1, 1'b0);
    cyc(SL + 4);
    @(posedge clk_i);
    wake <= 1'b1;
    cyc(8);
    rd_st();
    `CHK("mode", cxmw_pkg::MODE_STANDBY, s[2:0])
    `CHK("rxd", 1'b0, rxd)
    cyc(SL + 8);
    rd_st();
    `CHK("mode", cxmw_pkg::MODE_STANDBY, s[2:0])
    `CHK("sup_oe", 1'b1, sup_oe)
    pins(1'b1, 1'b1);
    `CHK("fault", 1'b0, fault_n)
    @(posedge clk_i);
    wake <= 1'b0;
    cyc(8);
    rd_st();
    `CHK("wake_request_flag", 1'b0, s[cxmw_pkg::ST_WAKE_REQUEST_FLAG_BIT])
    $display("test local done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence after a 16-cycle reset
  initial begin
    mismatches = 0;
    num_checks = 0;
    rst_i = 1'b1;
    req = '0;
    {txd, en, lp_n, wake, fail, send} = 6'b100000;
    io = 1'b1;
    dl = 9'd0;
    gl = 9'd0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc(4);
    t_reset();
    t_normal();
    t_silent();
    t_sleep();
    t_remote();
    t_local();
    close_out();
  end

  // Whole run needs roughly a thousand cycles
  initial begin
    #(40 * 20000);
    mismatches++;
    close_out();
  end
endmodule
